//--- hw/bsfs_pkg.sv
package bsfs_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int DECODE_MIN_US = 400;
   localparam int DECODE_MIN_CYC = (DECODE_MIN_US * (CLK_HZ / 1_000_000));
   localparam int FULL_DUTY_MS = 20;
   localparam int FULL_DUTY_CYC = FULL_DUTY_MS * (CLK_HZ / 1000);
   localparam int OC_SUSTAIN_MS = 2;
   localparam int OC_SUSTAIN_CYC = OC_SUSTAIN_MS * (CLK_HZ / 1000);
   localparam int NUM_CH = 6;
   localparam int CNT_W = 32;
   localparam logic [1:0] DIM_DIRECT = 2'h0;
   localparam logic [1:0] DIM_MIXED = 2'h1;
   localparam logic [1:0] DIM_ANALOG = 2'h2;
   localparam logic [1:0] SWITCH_FREQUENCY_SELECT_RESET = 2'h1;
   localparam logic [1:0] SLEW_RESET = 2'h0;
   localparam logic [3:0] SINK_RESET = 4'h5;
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam logic [2:0] UNDERVOLTAGE_THRESHOLD_RESET = 3'h3;
   // code 0..3 maps to 450/600/800/1200 kHz; code 0..3 to 1.3/2.5/3.5/4.6 V/ns
   typedef struct packed {
      logic [1:0] dim_mode;
      logic [3:0] sink_full_scale;
      logic [2:0] undervoltage_threshold;
      logic [1:0] switch_frequency_select;
      logic [1:0] slew_select;
      logic overcurrent_shutdown_enable;
   } bsfs_cfg_t;
   typedef struct packed {
      logic supply_above_on;
      logic supply_below_off;
      logic output_overvoltage_guard;
      logic ov_released;
      logic overcurrent;
      logic over_temp;
      logic temp_released;
      logic [NUM_CH-1:0] sink_zero;
   } bsfs_flt_t;
   typedef enum logic [2:0] {ST_OFF, ST_CHECK, ST_IDLE, ST_DECODE, ST_RUN, ST_LATCHED} bsfs_state_t;
endpackage

//--- hw/bsfs_sync.sv
`timescale 1ns/10ps
module bsfs_sync import bsfs_pkg::*; #(parameter int W = 1) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

//--- hw/bsfs_top.sv
`timescale 1ns/10ps
module bsfs_top import bsfs_pkg::*; #(
   parameter int DECODE_MIN = DECODE_MIN_CYC,
   parameter int FULL_DUTY = FULL_DUTY_CYC,
   parameter int OC_SUSTAIN = OC_SUSTAIN_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic chip_enable_pin,
   input wire logic dimming_pwm_input,
   input wire bsfs_cfg_t nv_cfg,
   input wire bsfs_flt_t fault_in,
   input wire logic cycle_start,
   output logic [1:0] switch_frequency_select,
   output logic [1:0] slew_select,
   output logic [3:0] sink_full_scale,
   output logic [2:0] undervoltage_threshold,
   output logic [1:0] dim_mode,
   output logic [NUM_CH-1:0] sink_enable,
   output logic boost_enable,
   output logic boost_min_level,
   output logic switch_gate,
   output logic regulate,
   output logic [9:0] duty_code,
   output logic low_power,
   output logic latched_fault
);
   ////////////////////////////////////////////////////////////////
   bsfs_flt_t flt;
   logic en_s, pwm_s;
   bsfs_sync #(.W($bits(bsfs_flt_t))) u_flt_sync (.clk(clk), .reset(reset), .d(fault_in), .q(flt));
   bsfs_sync #(.W(2)) u_pin_sync (.clk(clk), .reset(reset), .d({chip_enable_pin, dimming_pwm_input}),
      .q({en_s, pwm_s}));

   bsfs_state_t state_reg, state_next;
   bsfs_cfg_t cfg_reg;
   logic cfg_loaded_reg;
   logic pwm_d_reg;
   logic [NUM_CH-1:0] ch_on_reg;
   logic ov_halt_reg, oc_cut_reg, therm_reg, uv_ok_reg;
   logic [CNT_W-1:0] dec_cnt_reg, per_cnt_reg, hi_cnt_reg, oc_cnt_reg;
   logic [CNT_W-1:0] period_reg, high_reg;
   logic [1:0] edges_reg;
   logic [9:0] duty_reg;

   ////////////////////////////////////////////////////////////////
   function automatic logic is_direct(input logic [1:0] m);
      return m == DIM_DIRECT;
   endfunction

   wire rise = pwm_s & ~pwm_d_reg;
   wire fall = ~pwm_s & pwm_d_reg;
   wire all_open = (ch_on_reg == '0);
   wire oc_long = cfg_reg.overcurrent_shutdown_enable && (oc_cnt_reg >= CNT_W'(OC_SUSTAIN));
   wire uv_trip = uv_ok_reg & flt.supply_below_off;
   wire stop = ~en_s | uv_trip | therm_reg;
   wire dec_min_ok = dec_cnt_reg >= CNT_W'(DECODE_MIN);
   wire dec_done = is_direct(cfg_reg.dim_mode) ? 1'b1 : (edges_reg == 2'd2 && dec_min_ok);
   wire stuck_high = pwm_s && hi_cnt_reg >= CNT_W'(FULL_DUTY);
   wire none_left = (ch_on_reg & ~flt.sink_zero) == '0;
   wire active = state_reg == ST_IDLE || state_reg == ST_DECODE || state_reg == ST_RUN;

   // the only exit from the latched state is enable low or reset
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: if (en_s && uv_ok_reg && !therm_reg) state_next = ST_CHECK;
         ST_CHECK: if (stop) state_next = ST_OFF;
            else if (none_left) state_next = ST_LATCHED;
            else state_next = ST_IDLE;
         ST_IDLE: if (stop) state_next = ST_OFF;
            else if (rise) state_next = ST_DECODE;
         ST_DECODE: if (stop) state_next = ST_OFF;
            else if (dec_done || stuck_high) state_next = ST_RUN;
         ST_RUN: if (stop) state_next = ST_OFF;
            else if (all_open || oc_long) state_next = ST_LATCHED;
         ST_LATCHED: if (!en_s) state_next = ST_OFF;
         default: state_next = ST_OFF;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_OFF;
         pwm_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // held low until armed: a pin already high at enable still counts as the first edge
         pwm_d_reg <= active ? pwm_s : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // config captured once after reset release: live edits ignored
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_reg <= '{MODE_RESET, SINK_RESET, UNDERVOLTAGE_THRESHOLD_RESET, SWITCH_FREQUENCY_SELECT_RESET, SLEW_RESET, 1'b0};
         cfg_loaded_reg <= 1'b0;
      end else if (!cfg_loaded_reg) begin
         cfg_reg <= nv_cfg;
         cfg_loaded_reg <= 1'b1;
      end
   end

   assign switch_frequency_select = cfg_reg.switch_frequency_select;
   assign slew_select = cfg_reg.slew_select;
   assign sink_full_scale = cfg_reg.sink_full_scale;
   assign undervoltage_threshold = cfg_reg.undervoltage_threshold;
   assign dim_mode = cfg_reg.dim_mode;

   ////////////////////////////////////////////////////////////////
   // hysteresis latches from separate on/off comparators
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         uv_ok_reg <= 1'b0;
         ov_halt_reg <= 1'b0;
         therm_reg <= 1'b0;
      end else begin
         if (flt.supply_below_off) uv_ok_reg <= 1'b0;
         else if (flt.supply_above_on) uv_ok_reg <= 1'b1;
         if (flt.output_overvoltage_guard) ov_halt_reg <= 1'b1;
         else if (flt.ov_released) ov_halt_reg <= 1'b0;
         if (flt.over_temp) therm_reg <= 1'b1;
         else if (flt.temp_released) therm_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // per-sink open detect: once off, only enable low or reset brings it back
   wire sensing = (state_reg == ST_CHECK) || (state_reg == ST_RUN && !ov_halt_reg) ||
                  (state_reg == ST_RUN && ov_halt_reg);
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               ch_on_reg[g] <= 1'b1;
            end else if (state_reg == ST_OFF && !en_s) begin
               ch_on_reg[g] <= 1'b1;
            end else if (sensing && flt.sink_zero[g]) begin
               ch_on_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // cycle-by-cycle limit and sustained-overcurrent timer
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         oc_cut_reg <= 1'b0;
         oc_cnt_reg <= '0;
      end else begin
         if (flt.overcurrent) oc_cut_reg <= 1'b1;
         else if (cycle_start) oc_cut_reg <= 1'b0;
         if (state_reg != ST_RUN || !flt.overcurrent) oc_cnt_reg <= '0;
         else if (oc_cnt_reg != '1) oc_cnt_reg <= oc_cnt_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // duty measurement: period rise-to-rise, high time rise-to-fall
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dec_cnt_reg <= '0;
         per_cnt_reg <= '0;
         hi_cnt_reg <= '0;
         period_reg <= '0;
         high_reg <= '0;
         edges_reg <= 2'd0;
      end else begin
         if (state_reg != ST_DECODE) dec_cnt_reg <= '0;
         else if (!dec_min_ok) dec_cnt_reg <= dec_cnt_reg + 1'b1;
         if (state_reg == ST_IDLE) edges_reg <= 2'd0;
         else if (state_reg == ST_DECODE && rise && edges_reg != 2'd2) edges_reg <= edges_reg + 2'd1;
         if (rise) begin
            period_reg <= per_cnt_reg + 1'b1;
            per_cnt_reg <= '0;
            hi_cnt_reg <= '0;
         end else begin
            if (per_cnt_reg != '1) per_cnt_reg <= per_cnt_reg + 1'b1;
            if (pwm_s && hi_cnt_reg != '1) hi_cnt_reg <= hi_cnt_reg + 1'b1;
         end
         if (fall) high_reg <= hi_cnt_reg + 1'b1;
      end
   end

   // full-width divide: high time times 1024 over period, clamped to 3FF when over range or stuck high
   logic [CNT_W+9:0] scaled;
   assign scaled = {high_reg, 10'h000};
   wire [CNT_W+9:0] duty_raw = (period_reg == '0) ? '0 : scaled / {10'h000, period_reg};
   wire [9:0] duty_calc = (stuck_high || duty_raw > 42'h3FF) ? 10'h3FF : duty_raw[9:0];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) duty_reg <= 10'h000;
      else if (state_reg != ST_RUN) duty_reg <= 10'h000;
      else duty_reg <= is_direct(cfg_reg.dim_mode) ? {10{pwm_s}} : duty_calc;
   end

   ////////////////////////////////////////////////////////////////
   assign boost_enable = active && !ov_halt_reg;
   assign boost_min_level = state_reg == ST_IDLE || state_reg == ST_DECODE;
   assign switch_gate = boost_enable && !oc_cut_reg;
   assign regulate = state_reg == ST_RUN;
   assign sink_enable = regulate ? ch_on_reg : '0;
   assign duty_code = duty_reg;
   assign low_power = state_reg == ST_OFF || state_reg == ST_LATCHED;
   assign latched_fault = state_reg == ST_LATCHED;

   ////////////////////////////////////////////////////////////////
   a_enable_low_off: assert property (@(posedge clk) disable iff (reset)
      !en_s && state_reg != ST_LATCHED |=> low_power) else $error("enable low did not shut down");
   a_ov_halts_sw: assert property (@(posedge clk) disable iff (reset)
      ov_halt_reg |-> !switch_gate) else $error("switching during overvoltage");
   a_oc_cuts_gate: assert property (@(posedge clk) disable iff (reset)
      flt.overcurrent |=> !switch_gate) else $error("switch on after current limit");
   a_uv_trip_off: assert property (@(posedge clk) disable iff (reset)
      active && uv_trip |=> state_reg == ST_OFF) else $error("no undervoltage shutdown");
   a_therm_off: assert property (@(posedge clk) disable iff (reset)
      active && therm_reg |=> low_power) else $error("no thermal shutdown");
   a_latch_holds: assert property (@(posedge clk) disable iff (reset)
      latched_fault && en_s |=> latched_fault) else $error("latch left with enable high");
   a_direct_fast: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_DECODE && is_direct(cfg_reg.dim_mode) && !stop |=> regulate)
      else $error("direct mode delayed");
   a_decode_min: assert property (@(posedge clk) disable iff (reset)
      $rose(regulate) && !is_direct(cfg_reg.dim_mode) |-> $past(dec_min_ok) || $past(stuck_high))
      else $error("decoder delay too short");
   a_idle_min: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE |-> boost_min_level && sink_enable == '0) else $error("regulating while idle");
   a_open_sticky: assert property (@(posedge clk) disable iff (reset)
      !ch_on_reg[0] && en_s |=> !ch_on_reg[0]) else $error("open sink came back");
   ////////////////////////////////////////////////////////////////
   a_check_stop: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_CHECK && stop |=> low_power)
      else $error("check state ignored shutdown");
   a_uv_no_start: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_OFF && !uv_ok_reg |=> state_reg == ST_OFF)
      else $error("started below undervoltage");
   a_uv_falls_off: assert property (@(posedge clk) disable iff (reset)
      uv_ok_reg && flt.supply_below_off |=> !uv_ok_reg)
      else $error("supply ok kept below off level");
   a_ov_sets_halt: assert property (@(posedge clk) disable iff (reset)
      flt.output_overvoltage_guard |=> ov_halt_reg)
      else $error("overvoltage not latched");
   a_ov_hyst_hold: assert property (@(posedge clk) disable iff (reset)
      ov_halt_reg && !flt.ov_released |=> ov_halt_reg)
      else $error("overvoltage released early");
   a_therm_no_start: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_OFF && therm_reg |=> state_reg == ST_OFF)
      else $error("started while hot");
   a_therm_restart: assert property (@(posedge clk) disable iff (reset)
      therm_reg && !flt.over_temp && flt.temp_released |=> !therm_reg)
      else $error("thermal flag stuck after release");
   a_cfg_frozen: assert property (@(posedge clk) disable iff (reset)
      cfg_loaded_reg |=> $stable(cfg_reg))
      else $error("config changed after load");
   a_oc_latches: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && oc_long && !stop |=> latched_fault)
      else $error("sustained overcurrent not latched");
   a_oc_disabled: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && !cfg_reg.overcurrent_shutdown_enable && !all_open && !stop |=> regulate)
      else $error("overcurrent shutdown while disabled");
   a_all_open_off: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && all_open && !stop |=> latched_fault)
      else $error("running with every sink open");
   a_rise_decodes: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && rise && !stop |=> state_reg == ST_DECODE)
      else $error("dimming edge not taken");
   a_sink_drops: assert property (@(posedge clk) disable iff (reset)
      sensing && flt.sink_zero[0] |=> !ch_on_reg[0])
      else $error("zero current sink kept on");
   a_sink_reenable: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_OFF && !en_s |=> ch_on_reg == '1)
      else $error("sinks not restored by enable low");
   a_decode_waits: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_DECODE && !is_direct(cfg_reg.dim_mode) && !dec_done && !stuck_high |=> !regulate)
      else $error("decoder ended early");
   a_stuck_full: assert property (@(posedge clk) disable iff (reset)
      regulate && stuck_high && !is_direct(cfg_reg.dim_mode) |=> duty_code == 10'h3FF)
      else $error("stuck high input not full duty");
   a_check_unused: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_CHECK && !stop && none_left |=> latched_fault)
      else $error("started with no usable sink");
endmodule

//--- tb/bsfs_host_model.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////
// host side: enable pin and dimming source, moved on falling edges
module bsfs_host_model #(
   parameter int HALF = 4
) (
   input wire logic clk,
   input wire logic en_req,
   input wire logic [1:0] pwm_kind,
   output logic chip_enable_pin,
   output logic dimming_pwm_input
);
   int cnt = 0;
   logic en_q = 1'b0;
   logic [1:0] kind_q = 2'h0;
   // requests taken on the rising edge so a bench update on the falling edge cannot race
   always @(posedge clk) begin
      en_q <= en_req;
      kind_q <= pwm_kind;
   end
   initial begin
      chip_enable_pin = 1'b0;
      dimming_pwm_input = 1'b0;
   end
   // kind 0 held low, 1 square wave of period 2*HALF, 2 stuck high
   always @(negedge clk) begin
      chip_enable_pin <= en_q;
      cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
      if (kind_q == 2'h0) begin
         dimming_pwm_input <= 1'b0;
      end else if (kind_q == 2'h2) begin
         dimming_pwm_input <= 1'b1;
      end else if (cnt == HALF - 1) begin
         dimming_pwm_input <= ~dimming_pwm_input;
      end
   end
endmodule

//--- tb/backlight_startup_fault_supervisor_tb.sv
`timescale 1ns/10ps
module backlight_startup_fault_supervisor_tb;
   import bsfs_pkg::*;
   // short counts keep the run small; delays below derive from them
   localparam int DMIN = 20;
   localparam int FDUTY = 200;
   localparam int OCS = 30;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic en_req = 1'b0;
   logic [1:0] pwm_kind = 2'h0;
   logic cycle_start = 1'b0;
   bsfs_cfg_t nv_cfg = '0;
   bsfs_cfg_t cfg_seen;
   bsfs_flt_t fault_in = '0;
   logic chip_enable_pin, dimming_pwm_input;
   logic [1:0] switch_frequency_select, slew_select, dim_mode;
   logic [3:0] sink_full_scale;
   logic [2:0] undervoltage_threshold;
   logic [NUM_CH-1:0] sink_enable;
   logic boost_enable, boost_min_level, switch_gate, regulate, low_power, latched_fault;
   logic [9:0] duty_code;
   int n_fail = 0;
   int comparisons = 0;
   int seed = 59719;
   initial begin
      forever #4 clk = ~clk;
   end
   always @(negedge clk) begin
      cycle_start <= ($random(seed) % 4) == 0;
   end
   bsfs_top #(.DECODE_MIN(DMIN), .FULL_DUTY(FDUTY), .OC_SUSTAIN(OCS)) bsfs_top_i (.clk(clk), .reset(reset),
      .chip_enable_pin(chip_enable_pin), .dimming_pwm_input(dimming_pwm_input), .nv_cfg(nv_cfg),
      .fault_in(fault_in), .cycle_start(cycle_start), .switch_frequency_select(switch_frequency_select),
      .slew_select(slew_select), .sink_full_scale(sink_full_scale), .undervoltage_threshold(undervoltage_threshold),
      .dim_mode(dim_mode), .sink_enable(sink_enable), .boost_enable(boost_enable), .boost_min_level(boost_min_level),
      .switch_gate(switch_gate), .regulate(regulate), .duty_code(duty_code), .low_power(low_power),
      .latched_fault(latched_fault));
   bsfs_host_model #(.HALF(4)) bsfs_host_model_i (.clk(clk), .en_req(en_req), .pwm_kind(pwm_kind),
      .chip_enable_pin(chip_enable_pin), .dimming_pwm_input(dimming_pwm_input));
   //////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_reg(output int cyc);
      cyc = 0;
      while (regulate !== 1'b1 && cyc < 400) begin
         @(negedge clk);
         cyc++;
      end
   endtask
   // comparator levels of a healthy supply, rail and die
   task automatic power_up(input logic [1:0] mode, input logic oc_en);
      @(negedge clk);
      reset = 1'b1;
      en_req = 1'b0;
      pwm_kind = 2'h0;
      fault_in = '0;
      fault_in.supply_above_on = 1'b1;
      fault_in.ov_released = 1'b1;
      fault_in.temp_released = 1'b1;
      nv_cfg = 14'($random(seed));
      nv_cfg.dim_mode = mode;
      nv_cfg.overcurrent_shutdown_enable = oc_en;
      step(8);
      reset = 1'b0;
      step(3);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run();
   end
   initial begin
      int cyc;
      int lo;
      int hi;
      // k 3 is mixed mode fed a square wave, the others a stuck-high input
      for (int k = 0; k < 4; k++) begin
         power_up((k == 3) ? DIM_MIXED : 2'(k), 1'b0);
         check("switch_frequency_select", 10'(nv_cfg.switch_frequency_select), 10'(switch_frequency_select));
         check("slew", 10'(nv_cfg.slew_select), 10'(slew_select));
         check("sink scale", 10'(nv_cfg.sink_full_scale), 10'(sink_full_scale));
         check("undervoltage_threshold", 10'(nv_cfg.undervoltage_threshold), 10'(undervoltage_threshold));
         check("mode", 10'(nv_cfg.dim_mode), 10'(dim_mode));
         cfg_seen = nv_cfg;
         nv_cfg = ~nv_cfg;
         step(4);
         check("switch_frequency_select hold", 10'(cfg_seen.switch_frequency_select), 10'(switch_frequency_select));
         check("off power", 10'h001, 10'(low_power));
         en_req = 1'b1;
         step(10);
         check("min level", 10'h001, 10'(boost_min_level));
         check("no regulate", 10'h000, 10'(regulate));
         pwm_kind = (k == 3) ? 2'h1 : 2'h2;
         wait_reg(cyc);
         lo = (k == 0) ? 0 : (k == 3) ? DMIN : FDUTY;
         hi = (k == 0) ? 6 : (k == 3) ? DMIN + 24 : FDUTY + 10;
         check("decode delay", 10'h001, 10'(cyc >= lo && cyc <= hi));
         // duty register loads on the first edge in run; square wave is half duty
         step(1);
         check("duty", (k == 3) ? 10'h200 : 10'h3FF, duty_code);
         check("sinks on", 10'h03F, 10'(sink_enable));
         fault_in.sink_zero = 6'h04;
         step(6);
         fault_in.sink_zero = 6'h00;
         step(6);
         check("open sink", 10'h03B, 10'(sink_enable));
         check("others run", 10'h001, 10'(regulate));
         en_req = 1'b0;
         pwm_kind = 2'h0;
         step(8);
         check("shutdown", 10'h001, 10'(low_power));
         en_req = 1'b1;
         pwm_kind = 2'h2;
         wait_reg(cyc);
         check("sink back", 10'h03F, 10'(sink_enable));
         $display("test start mode %0d done", k);
      end
      for (int k = 0; k < 2; k++) begin
         power_up(DIM_DIRECT, k == 0);
         en_req = 1'b1;
         pwm_kind = 2'h2;
         wait_reg(cyc);
         fault_in.overcurrent = 1'b1;
         step(4);
         check("gate cut", 10'h000, 10'(switch_gate));
         step(OCS + 4);
         check("oc latch", 10'(k == 0), 10'(latched_fault));
         fault_in.overcurrent = 1'b0;
         step(6);
         check("latch held", 10'(k == 0), 10'(latched_fault));
         en_req = 1'b0;
         step(6);
         en_req = 1'b1;
         step(10);
         check("latch clear", 10'h000, 10'(latched_fault));
         $display("test overcurrent %0d done", k);
      end
      power_up(DIM_DIRECT, 1'b0);
      en_req = 1'b1;
      pwm_kind = 2'h2;
      wait_reg(cyc);
      fault_in.over_temp = 1'b1;
      fault_in.temp_released = 1'b0;
      step(5);
      check("hot off", 10'h000, 10'(boost_enable));
      fault_in.over_temp = 1'b0;
      fault_in.temp_released = 1'b1;
      step(10);
      check("cool on", 10'h001, 10'(boost_enable));
      fault_in.supply_below_off = 1'b1;
      fault_in.supply_above_on = 1'b0;
      step(5);
      check("uv off", 10'h000, 10'(boost_enable));
      fault_in.supply_below_off = 1'b0;
      step(10);
      check("uv wait", 10'h000, 10'(boost_enable));
      fault_in.supply_above_on = 1'b1;
      step(10);
      check("uv on", 10'h001, 10'(boost_enable));
      fault_in.output_overvoltage_guard = 1'b1;
      fault_in.ov_released = 1'b0;
      step(5);
      check("ov halt", 10'h000, 10'(boost_enable));
      fault_in.output_overvoltage_guard = 1'b0;
      step(5);
      check("ov hyst", 10'h000, 10'(boost_enable));
      fault_in.ov_released = 1'b1;
      step(5);
      check("ov resume", 10'h001, 10'(boost_enable));
      fault_in.sink_zero = 6'h3F;
      en_req = 1'b0;
      step(6);
      en_req = 1'b1;
      step(10);
      check("all open", 10'h000, 10'(boost_enable));
      $display("test faults done");
      complete_run();
   end
endmodule
